/* File: core/dpspi_pkg.sv */
// package: constants and types for the dual pot serial slave port
package dpspi_pkg;
   // ---------------------------------------------------------------
   // instruction byte layout
   // ---------------------------------------------------------------
   localparam int  INSTR_MSB      = 7;     // instruction field top bit
   localparam int  INSTR_LSB      = 5;     // instruction field low bit
   localparam int  ADDR_MSB       = 4;     // address field top bit
   localparam logic [2:0] OP_READ  = 3'h3; // read instruction code
   localparam logic [2:0] OP_WRITE = 3'h2; // write instruction code
   localparam logic [4:0] ADDR_POT0 = 5'h00; // wiper / initial value 0
   localparam logic [4:0] ADDR_POT1 = 5'h01; // wiper / initial value 1
   localparam logic [4:0] ADDR_ACCESS_CONTROL = 5'h10; // access control register
   localparam logic [4:0] ADDR_RSVD = 5'h0F; // reserved, reads zero
   // ---------------------------------------------------------------
   // access control register fields and reset values
   // ---------------------------------------------------------------
   localparam int  VOL_BIT        = 7;     // 1: volatile wipers only
   localparam int  SHDN_BIT       = 6;     // 0: shutdown
   localparam int  NVW_FLAG_BIT   = 5;     // nv write in progress, read only
   localparam int  SDO_OD_BIT     = 1;     // 1: open drain output
   localparam logic [7:0] ACCESS_CONTROL_RST = 8'h40; // shutdown off, push-pull
   localparam logic [7:0] WIPER_RST = 8'h80; // mid-scale at reset
   localparam logic [7:0] IVR_RST  = 8'h80; // initial value default
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int  CLK_HZ         = 20_000_000; // system clock rate
   localparam int  NVW_TIME_MS    = 20;         // longest nv write cycle
   localparam int  NVW_CYCLES     = NVW_TIME_MS * (CLK_HZ / 1000);
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] wiper0; // tap select, pot 0
      logic [7:0] wiper1; // tap select, pot 1
      logic       shdn_n; // low: pots in shutdown
   } dpspi_pot_t;
   typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_SKIP} dpspi_state_t;
endpackage

/* File: core/dpspi_slave.sv */
// serial slave port of a dual 256-tap digital potentiometer
//
// Operation
// - shift read data out on clock fall
// - capture input on clock rise, select low
// - output push-pull or open-drain per control bit1
// - select low means active and selected
// - select high: output pin high impedance
// - standby when deselected unless nv writing
// - value 255 high end, 0 low end
// - tap select driven from wiper register
// - decode opcode, address, data from input
// - nv write self-timed after sequence ends
// - msb first, clock mode 0
// - first byte: 3-bit opcode, 5-bit address
// - writes take effect at select rise
// - refuse wiper access and control writes while nv writing
`timescale 1ns/1ps
module dpspi_slave #(
   parameter int NVW_CYCLES = dpspi_pkg::NVW_CYCLES
) (
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire logic               spi_sck,
   input  wire logic               spi_cs_n,
   input  wire logic               spi_sdi,
   output logic                    spi_sdo_o,
   output logic                    spi_sdo_oe,
   output dpspi_pkg::dpspi_pot_t   pot,
   output logic                    active,
   output logic                    nv_busy
);
   // elaboration check: the nv timer needs at least one cycle
   if (NVW_CYCLES < 1) begin : g_bad_nvw
      $error("NVW_CYCLES must be at least 1");
   end
   // ---------------------------------------------------------------
   // input synchronisers and edge detection
   // ---------------------------------------------------------------
   logic [1:0] sck_s_r;   // clock sync pair
   logic [1:0] cs_s_r;    // select sync pair
   logic [1:0] sdi_s_r;   // data sync pair
   logic       sck_d_r;   // delayed synced clock
   logic       cs_d_r;    // delayed synced select
   // two flops per pin, then one more stage for edges
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sck_s_r <= 2'h0;
         cs_s_r  <= 2'h3;
         sdi_s_r <= 2'h0;
         sck_d_r <= 1'b0;
         cs_d_r  <= 1'b1;
      end else begin
         sck_s_r <= {sck_s_r[0], spi_sck};
         cs_s_r  <= {cs_s_r[0], spi_cs_n};
         sdi_s_r <= {sdi_s_r[0], spi_sdi};
         sck_d_r <= sck_s_r[1];
         cs_d_r  <= cs_s_r[1];
      end
   end
   logic sck_rise;  // synced clock rising
   logic sck_fall;  // synced clock falling
   logic cs_fall;   // select asserted
   logic cs_rise;   // select released
   logic sel;       // selected level
   assign sck_rise = sck_s_r[1] & ~sck_d_r;
   assign sck_fall = ~sck_s_r[1] & sck_d_r;
   assign cs_fall  = ~cs_s_r[1] & cs_d_r;
   assign cs_rise  = cs_s_r[1] & ~cs_d_r;
   assign sel      = ~cs_s_r[1];
   // ---------------------------------------------------------------
   // arming after reset
   // ---------------------------------------------------------------
   logic armed_r;   // seen a select fall since reset
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) armed_r <= 1'b0;
      else if (cs_fall) armed_r <= 1'b1;
   end
   logic live;      // transfer in progress and allowed
   assign live = armed_r & sel;
   // ---------------------------------------------------------------
   // receive shifter and framing
   // ---------------------------------------------------------------
   dpspi_pkg::dpspi_state_t state_r;  // framing state
   logic [2:0] bitcnt_r;   // bits in current byte
   logic [7:0] shin_r;     // input shift register
   logic [2:0] op_r;       // decoded opcode
   logic [4:0] addr_r;     // decoded address
   logic [7:0] wdata_r;    // last complete data byte
   logic       wvalid_r;   // a data byte arrived
   logic [7:0] byte_nxt;   // byte after this bit
   assign byte_nxt = {shin_r[6:0], sdi_s_r[1]};
   // shift on rise, decode at each byte boundary
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r  <= dpspi_pkg::ST_IDLE;
         bitcnt_r <= 3'h0;
         shin_r   <= 8'h00;
         op_r     <= 3'h0;
         addr_r   <= 5'h00;
         wdata_r  <= 8'h00;
         wvalid_r <= 1'b0;
      end else if (!live) begin
         state_r  <= dpspi_pkg::ST_IDLE;
         bitcnt_r <= 3'h0;
         wvalid_r <= wvalid_r & ~cs_rise & sel;
      end else if (cs_fall) begin
         state_r  <= dpspi_pkg::ST_INSTR;
         bitcnt_r <= 3'h0;
         wvalid_r <= 1'b0;
      end else if (sck_rise) begin
         shin_r   <= byte_nxt;
         bitcnt_r <= bitcnt_r + 3'h1;
         if (bitcnt_r == 3'h7) begin
            case (state_r)
               dpspi_pkg::ST_IDLE,
               dpspi_pkg::ST_INSTR: begin
                  op_r    <= byte_nxt[dpspi_pkg::INSTR_MSB:dpspi_pkg::INSTR_LSB];
                  addr_r  <= byte_nxt[dpspi_pkg::ADDR_MSB:0];
                  state_r <= dpspi_pkg::ST_DATA;
               end
               dpspi_pkg::ST_DATA: begin
                  wdata_r  <= byte_nxt;
                  wvalid_r <= 1'b1;
               end
               default: state_r <= dpspi_pkg::ST_SKIP;
            endcase
         end
      end
   end
   // ---------------------------------------------------------------
   // registers: wipers, initial values, access control
   // ---------------------------------------------------------------
   logic [7:0] wiper_r [2];  // wiper position registers
   logic [7:0] ivr_r [2];    // initial value registers
   logic [7:0] access_control_register_r;        // volatile control and status bits
   logic       nonvolatile_write_in_progress_r;  // nv write in progress
   logic [$clog2(NVW_CYCLES+1)-1:0] nvcnt_r;  // nv cycle timer
   logic       do_write;     // commit strobe
   logic       pot_hit;      // address selects a pot
   assign pot_hit  = (addr_r == dpspi_pkg::ADDR_POT0) | (addr_r == dpspi_pkg::ADDR_POT1);
   assign do_write = cs_rise & armed_r & wvalid_r & (op_r == dpspi_pkg::OP_WRITE);
   // commit on select rise; nv writes also start the timer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wiper_r[0] <= dpspi_pkg::WIPER_RST;
         wiper_r[1] <= dpspi_pkg::WIPER_RST;
         ivr_r[0]   <= dpspi_pkg::IVR_RST;
         ivr_r[1]   <= dpspi_pkg::IVR_RST;
         access_control_register_r <= dpspi_pkg::ACCESS_CONTROL_RST;
      end else if (do_write && !nonvolatile_write_in_progress_r) begin
         if (addr_r == dpspi_pkg::ADDR_ACCESS_CONTROL) begin
            access_control_register_r <= {wdata_r[7:6], 4'h0, wdata_r[dpspi_pkg::SDO_OD_BIT], 1'b0};
         end else if (pot_hit) begin
            wiper_r[addr_r[0]] <= wdata_r;
            if (!access_control_register_r[dpspi_pkg::VOL_BIT]) ivr_r[addr_r[0]] <= wdata_r;
         end
      end
   end
   // self-timed nv cycle, runs without serial clocking
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         nonvolatile_write_in_progress_r <= 1'b0;
         nvcnt_r                         <= '0;
      end else if (do_write && !nonvolatile_write_in_progress_r && pot_hit &&
                   !access_control_register_r[dpspi_pkg::VOL_BIT]) begin
         nonvolatile_write_in_progress_r <= 1'b1;
         nvcnt_r                         <= ($clog2(NVW_CYCLES+1))'(NVW_CYCLES - 1);
      end else if (nonvolatile_write_in_progress_r) begin
         if (nvcnt_r == '0) nonvolatile_write_in_progress_r <= 1'b0;
         else nvcnt_r <= nvcnt_r - 1'b1;
      end
   end
   // ---------------------------------------------------------------
   // read data selection and output shifter
   // ---------------------------------------------------------------
   function automatic logic [7:0] rd_sel(input logic [4:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == dpspi_pkg::ADDR_ACCESS_CONTROL) begin
         // status always readable, so the host can poll the nv flag
         v = access_control_register_r;
         v[dpspi_pkg::NVW_FLAG_BIT] = nonvolatile_write_in_progress_r;
      end else if (a == dpspi_pkg::ADDR_POT0 || a == dpspi_pkg::ADDR_POT1) begin
         if (nonvolatile_write_in_progress_r) v = 8'h00;
         else if (access_control_register_r[dpspi_pkg::VOL_BIT]) v = wiper_r[a[0]];
         else v = ivr_r[a[0]];
      end
      return v;
   endfunction
   logic [7:0] shout_r;   // output shift register
   logic       rd_en_r;   // read data phase active
   // load after instruction, shift on falling clock
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         shout_r <= 8'h00;
         rd_en_r <= 1'b0;
      end else if (!live) begin
         rd_en_r <= 1'b0;
      end else if (sck_fall) begin
         if (state_r == dpspi_pkg::ST_DATA && bitcnt_r == 3'h0 && !rd_en_r &&
             op_r == dpspi_pkg::OP_READ) begin
            shout_r <= rd_sel(addr_r);
            rd_en_r <= 1'b1;
         end else begin
            shout_r <= {shout_r[6:0], 1'b0};
         end
      end
   end
   // ---------------------------------------------------------------
   // pin drive and pot outputs
   // ---------------------------------------------------------------
   logic sdo_bit;   // current output bit
   // idle level 1 keeps an open-drain line released outside read data
   assign sdo_bit = rd_en_r ? shout_r[7] : 1'b1;
   always_comb begin
      if (!live) begin
         spi_sdo_o  = 1'b0;
         spi_sdo_oe = 1'b0;
      end else if (access_control_register_r[dpspi_pkg::SDO_OD_BIT]) begin
         spi_sdo_o  = 1'b0;
         spi_sdo_oe = ~sdo_bit;
      end else begin
         spi_sdo_o  = sdo_bit;
         spi_sdo_oe = 1'b1;
      end
   end
   assign pot.wiper0 = wiper_r[0];
   assign pot.wiper1 = wiper_r[1];
   assign pot.shdn_n = access_control_register_r[dpspi_pkg::SHDN_BIT];
   assign active     = sel | nonvolatile_write_in_progress_r;
   assign nv_busy    = nonvolatile_write_in_progress_r;
endmodule

/* File: testbench/dpspi_monitor.sv */
// checker: port timing rules of the dual pot serial slave
`timescale 1ns/1ps
module dpspi_monitor #(
   parameter int NVW_CYCLES = 50
) (
   input wire logic                  sys_clk,
   input wire logic                  rst,
   input wire logic                  spi_sck,
   input wire logic                  spi_cs_n,
   input wire logic                  spi_sdi,
   input wire logic                  spi_sdo_o,
   input wire logic                  spi_sdo_oe,
   input wire dpspi_pkg::dpspi_pot_t pot,
   input wire logic                  active,
   input wire logic                  nv_busy
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   int nv_cnt_r; // cycles the nv write has run
   // count busy cycles, cleared when idle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         nv_cnt_r <= 0;
      else
         nv_cnt_r <= nv_busy ? nv_cnt_r + 1 : 0;
   end
   property p_hiz;
      spi_cs_n [*4] |-> !spi_sdo_oe;
   endproperty
   a_hiz: assert property (p_hiz) else $error("sdo driven while deselected");
   property p_sel;
      !spi_cs_n [*4] |-> active;
   endproperty
   a_sel: assert property (p_sel) else $error("not active while selected");
   property p_stby;
      (spi_cs_n && !nv_busy) [*4] |-> !active;
   endproperty
   a_stby: assert property (p_stby) else $error("no standby when deselected");
   property p_nvact;
      nv_busy |-> active;
   endproperty
   a_nvact: assert property (p_nvact) else $error("standby during nv write");
   property p_commit;
      !$stable(pot) |-> spi_cs_n;
   endproperty
   a_commit: assert property (p_commit) else $error("wiper moved while selected");
   property p_nvstart;
      $rose(nv_busy) |-> spi_cs_n;
   endproperty
   a_nvstart: assert property (p_nvstart) else $error("nv write began while selected");
   property p_nvlen;
      $fell(nv_busy) |-> nv_cnt_r >= NVW_CYCLES - 1 && nv_cnt_r <= NVW_CYCLES + 1;
   endproperty
   a_nvlen: assert property (p_nvlen) else $error("nv write length wrong");
   property p_sdo;
      (spi_sck && !spi_cs_n && spi_sdo_oe) [*3] |-> $stable(spi_sdo_o);
   endproperty
   a_sdo: assert property (p_sdo) else $error("sdo moved while clock high");
   c_nv: cover property ($rose(nv_busy));
   c_rd: cover property ($rose(spi_sdo_oe));
   c_pot: cover property (!$stable(pot));
endmodule
bind dpspi_slave dpspi_monitor #(.NVW_CYCLES(NVW_CYCLES)) dpspi_monitor_i (
   .sys_clk(sys_clk), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
   .spi_sdi(spi_sdi), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe(spi_sdo_oe),
   .pot(pot), .active(active), .nv_busy(nv_busy));

/* File: testbench/dpspi_host.sv */
// partner: spi host, mode 0, 400 ns serial clock
`timescale 1ns/1ps
module dpspi_host (
   input  wire logic sys_clk,
   input  wire logic sdo_line,
   output logic      sck,
   output logic      cs_n,
   output logic      sdi,
   output logic [7:0] rx_byte,
   output logic      rx_vld
);
   initial begin
      sck = 0;
      cs_n = 1;
      sdi = 0;
      rx_byte = 0;
      rx_vld = 0;
   end
   // wait n clock edges, then step off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // one framed transfer of nb bits, msb first
   task automatic xfer(input logic [15:0] tx, input int nb, input bit rd);
      logic [15:0] rx;
      rx = '0;
      tick(1);
      cs_n = 0;
      tick(6);
      for (int i = 15; i > 15 - nb; i--) begin
         sdi = tx[i];
         tick(4);
         sck = 1;
         tick(4);
         rx[i] = sdo_line;
         sck = 0;
      end
      tick(6);
      cs_n = 1;
      sdi = ~sdi; // released line shows no stale value
      tick(44);
      if (rd) begin
         rx_byte = rx[7:0];
         rx_vld = 1;
         tick(1);
         rx_vld = 0;
      end
   endtask
endmodule

/* File: testbench/tb.sv */
// testbench: dual pot serial slave against the host model
`timescale 1ns/1ps
`define CHK(g,e) begin checked++; if ((g)!==(e)) begin err_total++; $display("Error t=%0t got %h exp %h",$time,g,e); end end
module tb;
   logic                  sys_clk, rst, sck, cs_n, sdi, sdo_o, sdo_oe, active, nv_busy, rx_vld;
   logic [7:0]            rx_byte, w0, e;
   dpspi_pkg::dpspi_pot_t pot;
   logic [7:0]            exp_q[$]; // expected read bytes
   int                    err_total, checked, seed, n;
   logic                  od;       // open-drain mode: line has a pull-up
   wire                   sdo_line = sdo_oe ? sdo_o : (od ? 1'b1 : ~sdo_o); // undriven line reads high in od mode, wrong otherwise
   dpspi_slave #(.NVW_CYCLES(1000)) dpspi_slave_i (.sys_clk(sys_clk), .rst(rst), .spi_sck(sck),
      .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo_o(sdo_o), .spi_sdo_oe(sdo_oe), .pot(pot),
      .active(active), .nv_busy(nv_busy));
   dpspi_host dpspi_host_i (.sys_clk(sys_clk), .sdo_line(sdo_line), .sck(sck), .cs_n(cs_n),
      .sdi(sdi), .rx_byte(rx_byte), .rx_vld(rx_vld));
   initial begin
      sys_clk = 0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic tally_and_finish();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      dpspi_host_i.xfer({dpspi_pkg::OP_WRITE, a, d}, 16, 1'b0);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] x);
      exp_q.push_back(x);
      dpspi_host_i.xfer({dpspi_pkg::OP_READ, a, 8'h00}, 16, 1'b1);
   endtask
   // compare each returned byte with the oldest note
   always @(posedge sys_clk) begin
      if (rx_vld === 1'b1) begin
         e = exp_q.pop_front();
         `CHK(rx_byte, e)
      end
   end
   // open drain may only ever pull the line low
   always @(negedge sys_clk) begin
      if (od === 1'b1 && sdo_oe === 1'b1) `CHK(sdo_o, 1'b0)
   end
   initial begin
      #2000000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      seed = 80;
      od = 1'b0;
      err_total = 0;
      checked = 0;
      rst = 1;
      repeat (12) @(posedge sys_clk);
      #1 rst = 0;
      `CHK(pot, {8'h80, 8'h80, 1'b1})
      `CHK(sdo_oe, 1'b0)
      $display("test reset done");
      wr(dpspi_pkg::ADDR_ACCESS_CONTROL, 8'hC0);
      w0 = 8'($random(seed));
      wr(dpspi_pkg::ADDR_POT0, w0);
      wr(dpspi_pkg::ADDR_POT1, 8'hFF);
      `CHK(pot, {w0, 8'hFF, 1'b1})
      rd(dpspi_pkg::ADDR_POT0, w0);
      rd(dpspi_pkg::ADDR_ACCESS_CONTROL, 8'hC0);
      rd(dpspi_pkg::ADDR_RSVD, 8'h00);
      dpspi_host_i.xfer({dpspi_pkg::OP_WRITE, dpspi_pkg::ADDR_POT1, 8'h00}, 13, 1'b0);
      `CHK(pot.wiper1, 8'hFF)
      $display("test volatile access done");
      wr(dpspi_pkg::ADDR_ACCESS_CONTROL, 8'hC2);
      od = 1'b1;
      rd(dpspi_pkg::ADDR_POT0, w0);
      rd(dpspi_pkg::ADDR_ACCESS_CONTROL, 8'hC2);
      $display("test open drain done");
      wr(dpspi_pkg::ADDR_ACCESS_CONTROL, 8'h40);
      od = 1'b0;
      wr(dpspi_pkg::ADDR_POT1, 8'h00);
      `CHK(nv_busy, 1'b1)
      `CHK(active, 1'b1)
      rd(dpspi_pkg::ADDR_ACCESS_CONTROL, 8'h60);
      wr(dpspi_pkg::ADDR_POT0, 8'h11);
      for (n = 0; n < 3000 && nv_busy === 1'b1; n++) dpspi_host_i.tick(1);
      if (n == 3000) begin
         err_total++;
         tally_and_finish();
      end
      `CHK(pot, {w0, 8'h00, 1'b1})
      `CHK(active, 1'b0)
      rd(dpspi_pkg::ADDR_POT1, 8'h00);
      `CHK(exp_q.size(), 0)
      $display("test nv write done");
      tally_and_finish();
   end
endmodule
